// *** cmp_analog_model.sv ***
`timescale 1ns/100ps
module cmp_analog_model
(
   input wire logic vref_sel_in,
   input wire logic one_neg_alt_in,
   input wire logic two_neg_alt_in,
   input wire logic cmps_off_in,
   input wire logic [11:0] vref_mv_in,
   input wire logic [23:0] pos_mv_in,
   input wire logic [47:0] pin_mv_in,
   input wire logic [5:0] pin_data_in,
   input wire logic [5:0] pin_oe_n_in,
   input wire logic [5:0] pin_ext_in,
   output logic [1:0] cmp_raw_out,
   output logic [5:0] pin_out
);
   logic [11:0] pos_one;
   logic [11:0] pos_two;
   logic [11:0] neg_one;
   logic [11:0] neg_two;
   // ---------------------------------
   // Analog input selection, compare and pin drive
   // ---------------------------------
   always_comb
   begin
      pos_one = vref_sel_in ? vref_mv_in : pos_mv_in[11:0];
      pos_two = vref_sel_in ? vref_mv_in : pos_mv_in[23:12];
      neg_one = one_neg_alt_in ? pin_mv_in[47:36] : pin_mv_in[11:0];
      neg_two = two_neg_alt_in ? pin_mv_in[35:24] : pin_mv_in[23:12];
      cmp_raw_out[0] = !cmps_off_in && (pos_one > neg_one);
      cmp_raw_out[1] = !cmps_off_in && (pos_two > neg_two);
      for (int i = 0; i < 6; i++)
      begin
         pin_out[i] = pin_oe_n_in[i] ? pin_ext_in[i] : pin_data_in[i];
      end
   end
endmodule : cmp_analog_model

// *** cmp_ctrl.sv ***
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "cmp_ctrl_map.svh"
module cmp_ctrl
(
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input cmp_ctrl_pkg::reg_byte_type wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output cmp_ctrl_pkg::reg_byte_type rdata_out,
   input wire logic [1:0] cmp_raw_in,
   input wire logic sleep_in,
   input cmp_ctrl_pkg::port_bits_type pin_in,
   output cmp_ctrl_pkg::port_bits_type pin_data_out,
   output cmp_ctrl_pkg::port_bits_type pin_oe_n_out,
   output logic cmps_off_out,
   output logic vref_sel_out,
   output logic one_neg_alt_out,
   output logic two_neg_alt_out,
   output logic cmp_irq_req_out,
   output logic wake_out,
   output logic irq_out
);
   import cmp_ctrl_pkg::*;

   // ---------------------------------
   // Address decode
   // ---------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic ctrl_wr;
   logic ctrl_rd;
   logic ctrl_access;
   assign ctrl_wr = wr_in & hit(addr_in, `OFS_CTRL);
   assign ctrl_rd = rd_in & hit(addr_in, `OFS_CTRL);
   assign ctrl_access = ctrl_wr | ctrl_rd;

   // ---------------------------------
   // Control register
   // ---------------------------------
   cmp_mode_type mode_q;
   logic [1:0] inv_q;
   logic switch_q;

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mode_q <= cmp_mode_type'(3'(`CTRL_RST));
         inv_q <= 2'h0;
         switch_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         mode_q <= cmp_mode_type'(wdata_in[2:0]);
         inv_q <= {wdata_in[`BIT_TWO_INV], wdata_in[`BIT_ONE_INV]};
         switch_q <= wdata_in[`BIT_SWITCH];
      end
   end

   logic [3:0] analog_pins;
   logic route_one;
   logic route_two;

   cmp_mode_decode u_decode
   (
      .mode_in(mode_q),
      .switch_in(switch_q),
      .cmps_off_out(cmps_off_out),
      .vref_sel_out(vref_sel_out),
      .one_neg_alt_out(one_neg_alt_out),
      .two_neg_alt_out(two_neg_alt_out),
      .route_one_out(route_one),
      .route_two_out(route_two),
      .analog_pins_out(analog_pins)
   );

   // ---------------------------------
   // Result path
   // ---------------------------------
   logic [1:0] res_sync;
   logic [1:0] live;
   logic [1:0] raw_res;

   cmp_sync u_sync
   (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .async_in(cmp_raw_in),
      .sync_out(res_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_res
         // Off comparators report low before inversion
         assign live[gi] = (res_sync[gi] & ~cmps_off_out) ^ inv_q[gi];
         assign raw_res[gi] = (cmp_raw_in[gi] & ~cmps_off_out) ^ inv_q[gi];
      end
   endgenerate

   // ---------------------------------
   // Mismatch capture
   // ---------------------------------
   logic [1:0] last_q;
   logic mismatch;
   assign mismatch = (live != last_q);

   // A change in the access cycle is absorbed here
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         last_q <= 2'h0;
      else if (ctrl_access)
         last_q <= live;
   end

   // ---------------------------------
   // Interrupt flag and enables
   // ---------------------------------
   logic flag_q;
   logic cmp_en_q;
   logic periph_en_q;
   logic global_en_q;
   logic flags_wr;

   assign flags_wr = wr_in & hit(addr_in, `OFS_FLAGS);

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         flag_q <= 1'b0;
      else if (mismatch)
         flag_q <= 1'b1;
      else if (flags_wr)
         flag_q <= wdata_in[`BIT_CMP_FLAG];
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cmp_en_q <= 1'b0;
      else if (wr_in && hit(addr_in, `OFS_ENABLES))
         cmp_en_q <= wdata_in[`BIT_CMP_EN];
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         global_en_q <= 1'b0;
         periph_en_q <= 1'b0;
      end
      else if (wr_in && hit(addr_in, `OFS_IRQ_CTRL))
      begin
         global_en_q <= wdata_in[`BIT_GLOBAL_EN];
         periph_en_q <= wdata_in[`BIT_PERIPH_EN];
      end
   end

   assign cmp_irq_req_out = flag_q & cmp_en_q & periph_en_q & global_en_q;
   // Sleep gates only wake here, so wake needs no global enable
   assign wake_out = sleep_in & flag_q & cmp_en_q & periph_en_q;

   // ---------------------------------
   // Port pins
   // ---------------------------------
   port_bits_type dir_q;
   port_bits_type latch_q;

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         dir_q <= `DIR_RST;
      else if (wr_in && hit(addr_in, `OFS_DIR))
         dir_q <= wdata_in[5:0];
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         latch_q <= 6'h00;
      else if (wr_in && hit(addr_in, `OFS_LATCH))
         latch_q <= wdata_in[5:0];
   end

   always_comb
   begin
      pin_data_out = latch_q;
      if (route_one)
         pin_data_out[`PIN_ONE_OUT] = raw_res[0];
      if (route_two)
         pin_data_out[`PIN_TWO_OUT] = raw_res[1];
   end

   assign pin_oe_n_out = dir_q;

   port_bits_type port_rd;
   assign port_rd = pin_in & ~{2'h0, analog_pins};

   // ---------------------------------
   // Event status and mask
   // ---------------------------------
   logic [1:0] evt_stat_q;
   logic [1:0] evt_mask_q;
   logic [1:0] live_prev_q;
   logic stat_rd;

   assign stat_rd = rd_in & hit(addr_in, `OFS_EVT_STAT);

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         live_prev_q <= 2'h0;
      else
         live_prev_q <= live;
   end

   // Set wins over the clearing read
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         evt_stat_q <= 2'h0;
      else
         evt_stat_q <= (stat_rd ? 2'h0 : evt_stat_q) | (live ^ live_prev_q);
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         evt_mask_q <= 2'h0;
      else if (wr_in && hit(addr_in, `OFS_EVT_MASK))
         evt_mask_q <= wdata_in[1:0];
   end

   assign irq_out = |(evt_stat_q & evt_mask_q);

   // ---------------------------------
   // Read data
   // ---------------------------------
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_out <= 8'h00;
      else if (rd_in)
      begin
         unique case (addr_in)
            `OFS_CTRL: rdata_out <= {live, inv_q, switch_q, mode_q};
            `OFS_FLAGS: rdata_out <= {1'b0, flag_q, 6'h00};
            `OFS_ENABLES: rdata_out <= {1'b0, cmp_en_q, 6'h00};
            `OFS_IRQ_CTRL: rdata_out <= {global_en_q, periph_en_q, 6'h00};
            `OFS_DIR: rdata_out <= {2'h0, dir_q};
            `OFS_LATCH: rdata_out <= {2'h0, latch_q};
            `OFS_PORT: rdata_out <= {2'h0, port_rd};
            `OFS_EVT_STAT: rdata_out <= {6'h00, evt_stat_q};
            `OFS_EVT_MASK: rdata_out <= {6'h00, evt_mask_q};
            default: rdata_out <= 8'h00;
         endcase
      end
      else
         rdata_out <= 8'h00;
   end

   // ---------------------------------
   // Assertions
   // ---------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   a_flag_on_mismatch: assert property (mismatch |=> flag_q)
      else $error("flag not set on mismatch");
   a_mismatch_ends: assert property (ctrl_access ##1 $stable(live) |-> !mismatch)
      else $error("access did not end mismatch");
   a_irq_enables: assert property (cmp_irq_req_out |-> flag_q && cmp_en_q && periph_en_q && global_en_q)
      else $error("request without all enables");
   a_flag_sw_set: assert property (flags_wr && wdata_in[`BIT_CMP_FLAG] |=> flag_q)
      else $error("software set of flag lost");
   a_flag_sw_clear: assert property (flags_wr && !wdata_in[`BIT_CMP_FLAG] && !mismatch |=> !flag_q)
      else $error("software clear of flag lost");
   a_result_bits: assert property (ctrl_rd |=> rdata_out[7:6] == $past(live))
      else $error("result bits wrong on read");
   a_ro_result: assert property (ctrl_wr ##1 ctrl_rd && $stable(live) |=> rdata_out[7:6] == $past(live))
      else $error("write altered result bits");
   a_invert_live: assert property (!cmps_off_out |-> live == (res_sync ^ inv_q))
      else $error("inversion not applied");
   a_vref_only_110: assert property (vref_sel_out |-> mode_q == MODE_FOUR_MUX_VREF)
      else $error("reference selected outside mode 110");
   a_switch_only_110: assert property (one_neg_alt_out |-> mode_q == MODE_FOUR_MUX_VREF && switch_q)
      else $error("switch acted outside mode 110");
   a_mode_write: assert property (ctrl_wr |=> mode_q == $past(wdata_in[2:0]))
      else $error("mode field not written");
   a_pin_route: assert property (route_two |-> pin_data_out[`PIN_TWO_OUT] == raw_res[1])
      else $error("routed pin not raw result");
   a_pin_oe: assert property (wr_in && hit(addr_in, `OFS_DIR) |=> pin_oe_n_out == $past(wdata_in[5:0]))
      else $error("direction not driving enables");
   a_analog_zero: assert property (rd_in && hit(addr_in, `OFS_PORT) |=> (rdata_out[3:0] & $past(analog_pins)) == 4'h0)
      else $error("analog pin read nonzero");
   a_ctrl_keep: assert property (sleep_in && !ctrl_wr |=> $stable(mode_q) && $stable(inv_q))
      else $error("control changed without write");
   a_sync_delay: assert property ((!cmps_off_out && $stable(cmps_off_out) && $stable(inv_q)
      && $stable(cmp_raw_in)) [*3] |-> live == (cmp_raw_in ^ inv_q))
      else $error("sync delay not two cycles");

   c_flag_set: cover property (mismatch ##1 flag_q);
   c_irq_req: cover property ($rose(cmp_irq_req_out));
   c_wake: cover property (sleep_in && wake_out);
   c_route: cover property (route_one && route_two && !pin_oe_n_out[`PIN_ONE_OUT]);
endmodule : cmp_ctrl

// *** cmp_ctrl_map.svh ***
`ifndef CMP_CTRL_MAP_SVH
`define CMP_CTRL_MAP_SVH
// ---------------------------------
// Register offsets
// ---------------------------------
`define OFS_CTRL 8'h00
`define OFS_FLAGS 8'h01
`define OFS_ENABLES 8'h02
`define OFS_IRQ_CTRL 8'h03
`define OFS_DIR 8'h04
`define OFS_LATCH 8'h05
`define OFS_PORT 8'h06
`define OFS_EVT_STAT 8'h07
`define OFS_EVT_MASK 8'h08
// ---------------------------------
// Field positions
// ---------------------------------
`define BIT_TWO_RES 7
`define BIT_ONE_RES 6
`define BIT_TWO_INV 5
`define BIT_ONE_INV 4
`define BIT_SWITCH 3
`define BIT_CMP_FLAG 6
`define BIT_CMP_EN 6
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define PIN_ONE_OUT 4
`define PIN_TWO_OUT 5
// ---------------------------------
// Reset values and sync stage count
// ---------------------------------
`define CTRL_RST 8'h07
`define DIR_RST 6'h3f
`define SYNC_STAGES 2
`endif

// *** cmp_ctrl_pkg.sv ***
package cmp_ctrl_pkg;
   typedef enum logic [2:0]
   {
      MODE_RESET_ANALOG = 3'h0,
      MODE_ONE_INDEP = 3'h1,
      MODE_TWO_INDEP = 3'h2,
      MODE_TWO_COMMON_OUT = 3'h3,
      MODE_TWO_COMMON = 3'h4,
      MODE_ONE_INDEP_OUT = 3'h5,
      MODE_FOUR_MUX_VREF = 3'h6,
      MODE_OFF = 3'h7
   } cmp_mode_type;
   typedef logic [7:0] reg_byte_type;
   typedef logic [5:0] port_bits_type;
endpackage : cmp_ctrl_pkg

// *** cmp_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "cmp_ctrl_map.svh"
module cmp_ctrl_tb;
   import cmp_ctrl_pkg::*;
   logic core_clk_in, arst_n_in, wr_in, rd_in, sleep_in;
   logic [7:0] addr_in;
   reg_byte_type wdata_in, rdata_out;
   logic [1:0] cmp_raw_in;
   port_bits_type pin_in, pin_data_out, pin_oe_n_out, pin_ext;
   logic cmps_off_out, vref_sel_out, one_neg_alt_out, two_neg_alt_out;
   logic cmp_irq_req_out, wake_out, irq_out;
   logic [23:0] pos_mv;
   logic [47:0] pin_mv;
   logic [11:0] vref_mv;
   int err_total, checked;
   // Control byte, then off, vref, one alt, two alt
   logic [15:0] rows [8] = '{16'h0e07, 16'h0604, 16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0500, 16'h0708};

   cmp_ctrl dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cmp_raw_in(cmp_raw_in), .sleep_in(sleep_in),
      .pin_in(pin_in), .pin_data_out(pin_data_out), .pin_oe_n_out(pin_oe_n_out), .cmps_off_out(cmps_off_out),
      .vref_sel_out(vref_sel_out), .one_neg_alt_out(one_neg_alt_out), .two_neg_alt_out(two_neg_alt_out),
      .cmp_irq_req_out(cmp_irq_req_out), .wake_out(wake_out), .irq_out(irq_out));
   cmp_analog_model far (.vref_sel_in(vref_sel_out), .one_neg_alt_in(one_neg_alt_out),
      .two_neg_alt_in(two_neg_alt_out), .cmps_off_in(cmps_off_out), .vref_mv_in(vref_mv), .pos_mv_in(pos_mv),
      .pin_mv_in(pin_mv), .pin_data_in(pin_data_out), .pin_oe_n_in(pin_oe_n_out), .pin_ext_in(pin_ext),
      .cmp_raw_out(cmp_raw_in), .pin_out(pin_in));
   // ---------------------------------
   // Bus and compare tasks
   // ---------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask : rd
   task automatic close_out();
      $display("errors=%0d checks=%0d", err_total, checked);
      if (err_total == 0 && checked > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   // ---------------------------------
   // Clock and watchdog
   // ---------------------------------
   initial
   begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      repeat (3000) @(posedge core_clk_in);
      err_total++;
      close_out();
   end
   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial
   begin
      arst_n_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      sleep_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 8'h00;
      pos_mv = 24'h00_0000;
      pin_mv = 48'h8008_0080_0080;
      vref_mv = 12'h000;
      pin_ext = 6'h3f;
      repeat (12) @(posedge core_clk_in);
      #1 chk({cmps_off_out, vref_sel_out, irq_out, wake_out, 4'h0}, 8'h80);
      chk({2'h0, pin_oe_n_out}, 8'h3f);
      @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      rd(`OFS_CTRL, 8'h07);
      foreach (rows[i])
      begin
         wr(`OFS_CTRL, 8'hc0 | rows[i][15:8]);
         #1 chk({4'h0, cmps_off_out, vref_sel_out, one_neg_alt_out, two_neg_alt_out}, {4'h0, rows[i][3:0]});
         rd(`OFS_CTRL, rows[i][15:8]);
      end
      // Mode changed while interrupts still disabled
      wr(`OFS_CTRL, 8'h03);
      rd(`OFS_CTRL, 8'h03);
      wr(`OFS_ENABLES, 8'h40);
      wr(`OFS_IRQ_CTRL, 8'hc0);
      wr(`OFS_EVT_MASK, 8'h01);
      @(posedge core_clk_in);
      pos_mv <= 24'h00_0100;
      repeat (4) @(posedge core_clk_in);
      #1 chk({6'h00, cmp_irq_req_out, irq_out}, 8'h03);
      chk({6'h00, pin_data_out[5:4]}, 8'h01);
      wr(`OFS_FLAGS, 8'h00);
      rd(`OFS_FLAGS, 8'h40);
      rd(`OFS_CTRL, 8'h43);
      wr(`OFS_FLAGS, 8'h00);
      rd(`OFS_FLAGS, 8'h00);
      wr(`OFS_IRQ_CTRL, 8'h40);
      wr(`OFS_FLAGS, 8'h40);
      #1 chk({7'h00, cmp_irq_req_out}, 8'h00);
      rd(`OFS_FLAGS, 8'h40);
      rd(`OFS_EVT_STAT, 8'h01);
      #1 chk({7'h00, irq_out}, 8'h00);
      rd(8'h20, 8'h00);
      // Inversion, routing and direction gating
      wr(`OFS_CTRL, 8'h13);
      #1 chk({6'h00, pin_data_out[5:4]}, 8'h00);
      rd(`OFS_CTRL, 8'h13);
      wr(`OFS_DIR, 8'h2f);
      #1 chk({2'h0, pin_oe_n_out}, 8'h2f);
      rd(`OFS_PORT, 8'h20);
      // Change during sleep must wake
      @(posedge core_clk_in);
      sleep_in <= 1'b1;
      rd(`OFS_CTRL, 8'h13);
      wr(`OFS_FLAGS, 8'h00);
      @(posedge core_clk_in);
      pos_mv <= 24'h00_0000;
      repeat (4) @(posedge core_clk_in);
      #1 chk({7'h00, wake_out}, 8'h01);
      @(posedge core_clk_in);
      sleep_in <= 1'b0;
      rd(`OFS_CTRL, 8'h53);
      // Write then read with no gap between strobes
      @(posedge core_clk_in);
      addr_in <= `OFS_CTRL;
      wdata_in <= 8'hd7;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, 8'h57);
      // Reset in mid-run restores every register
      @(posedge core_clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      #1 chk({2'h0, pin_oe_n_out}, 8'h3f);
      chk({cmps_off_out, vref_sel_out, irq_out, wake_out, cmp_irq_req_out, 3'h0}, 8'h80);
      @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      rd(`OFS_CTRL, 8'h07);
      rd(`OFS_FLAGS, 8'h00);
      close_out();
   end
endmodule : cmp_ctrl_tb

// *** cmp_mode_decode.sv ***
`timescale 1ns/100ps
`include "cmp_ctrl_map.svh"
module cmp_mode_decode
(
   input cmp_ctrl_pkg::cmp_mode_type mode_in,
   input wire logic switch_in,
   output logic cmps_off_out,
   output logic vref_sel_out,
   output logic one_neg_alt_out,
   output logic two_neg_alt_out,
   output logic route_one_out,
   output logic route_two_out,
   output logic [3:0] analog_pins_out
);
   import cmp_ctrl_pkg::*;
   always_comb
   begin
      cmps_off_out = 1'b0;
      vref_sel_out = 1'b0;
      route_one_out = 1'b0;
      route_two_out = 1'b0;
      analog_pins_out = 4'hf;
      unique case (mode_in)
         MODE_OFF:
         begin
            cmps_off_out = 1'b1;
            analog_pins_out = 4'h0;
         end
         MODE_TWO_COMMON_OUT:
         begin
            route_one_out = 1'b1;
            route_two_out = 1'b1;
         end
         MODE_ONE_INDEP_OUT:
            route_two_out = 1'b1;
         MODE_FOUR_MUX_VREF:
            vref_sel_out = 1'b1;
         MODE_RESET_ANALOG, MODE_ONE_INDEP, MODE_TWO_INDEP, MODE_TWO_COMMON:
            analog_pins_out = 4'hf;
      endcase
   end
   // Switch only acts in the four input mode
   assign one_neg_alt_out = vref_sel_out & switch_in;
   assign two_neg_alt_out = vref_sel_out & switch_in;
endmodule : cmp_mode_decode

// *** cmp_sync.sv ***
`timescale 1ns/100ps
`include "cmp_ctrl_map.svh"
module cmp_sync
(
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic [1:0] async_in,
   output logic [1:0] sync_out
);
   logic [1:0] meta_q;
   // ---------------------------------
   // Two stage capture per bit
   // ---------------------------------
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         meta_q <= 2'h0;
         sync_out <= 2'h0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cmp_sync
